// ===== rtl/gpio_pkg.sv
// Notes on behaviour
// [R1] Modes 1-4: low port direction reads all ones, ignores writes, pins drive A7..A0.
// [R2] Modes 1-4: high port direction fixed all ones, pins drive A15..A8.
// [R3] Modes 5-6: low port pin outputs address bit if direction 1, else input.
// [R4] Modes 5-6: high port pin outputs address bit if direction 1, else input.
// [R5] Modes 5-6: high port pins are inputs after reset until software sets direction.
// [R6] Mode 7: low port pin drives data latch if direction 1, else input.
// [R7] Mode 7: high port pin drives data latch if direction 1, else input.
// [R8] Modes 5-7: direction registers are write-only and read all ones.
// [R9] Direction registers clear on reset and hardware standby, hold in software standby.
// [R10] Software standby: output pins keep driving their pre-standby level.
// [R11] Low data read returns pin level where direction 0, latch where 1.
// [R12] Low data latch read/write, clears on reset and hardware standby, holds in software standby.
// [R13] High direction at FFC1, high data at FFC3.
// [R14] High pull-up enable at FFD8, read/write, resets to zero.
// [R15] DRAM in area 3: two lowest high-port address pins carry row/column multiplexed address.
// [R16] Modes 1-4: low port pins are dedicated outputs of address bits 7..0.
// [R17] High data read returns pin level where direction 0, latch where 1.
// [R18] Pull-up on only in modes 5-7 with pull-up 1 and direction 0; else off. Mode 0 decodes as expanded and turns it on too.
package gpio_pkg;
	localparam int unsigned PORT_W = 8;
	localparam int unsigned ADDR_W = 16;
	localparam logic [ADDR_W-1:0] LOW_DIR_ADDR = 16'hffc0;
	localparam logic [ADDR_W-1:0] HIGH_DIR_ADDR = 16'hffc1;
	localparam logic [ADDR_W-1:0] LOW_DATA_ADDR = 16'hffc2;
	localparam logic [ADDR_W-1:0] HIGH_DATA_ADDR = 16'hffc3;
	localparam logic [ADDR_W-1:0] HIGH_PULLUP_ADDR = 16'hffd8;
	// Printed offsets are byte-granular, so the APB byte address is four times the index
	localparam int unsigned ADDR_SHIFT = 2;
	localparam logic [PORT_W-1:0] REG_RESET = 8'h00;
	localparam logic [PORT_W-1:0] ALL_ONES = 8'hff;
	localparam logic [2:0] MODE_LAST_EXPANDED = 3'h4;
	localparam logic [2:0] MODE_SINGLE_CHIP = 3'h7;
	localparam logic [2:0] MODE_FIRST = 3'h1;
	localparam int unsigned DRAM_MUX_BITS = 2;
	typedef logic [PORT_W-1:0] port_t;
	typedef enum logic [2:0]
	{
		MODE_ROMLESS = 3'b001,
		MODE_EXPANDED = 3'b010,
		MODE_SINGLE = 3'b100
	} mode_class_e;
endpackage : gpio_pkg

// ===== rtl/port_regs_if.sv
`timescale 1ns/1ps
interface port_regs_if;
	import gpio_pkg::*;
	port_t dir;
	port_t latch;
	port_t addr;
	port_t pin_in;
	logic addr_mode;
	logic latch_mode;
	logic hold;
	port_t pin_out;
	port_t pin_oe_n;
	port_t readback;
	modport ctrl (output dir, latch, addr, pin_in, addr_mode, latch_mode, hold, input pin_out, pin_oe_n, readback);
	modport pin (input dir, latch, addr, pin_in, addr_mode, latch_mode, hold, output pin_out, pin_oe_n, readback);
endinterface : port_regs_if

// ===== rtl/pin_mux.sv
`timescale 1ns/1ps
module pin_mux
(
	input wire logic clk_sys,
	input wire logic rst_n,
	port_regs_if.pin p
);
	import gpio_pkg::*;
	port_t out_q;
	port_t out_d;
	port_t drive;
	genvar i;
	generate
		for (i = 0; i < PORT_W; i++)
		begin : g_bit
			assign out_d[i] = p.addr_mode ? p.addr[i] : p.latch[i]; // [R3] [R4] [R6] [R7]
			assign drive[i] = p.dir[i] & (p.addr_mode | p.latch_mode);
			assign p.readback[i] = p.dir[i] ? p.latch[i] : p.pin_in[i]; // [R11] [R17]
		end
	endgenerate
	// Output register freezes during software standby
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			out_q <= REG_RESET;
		else if (!p.hold)
			out_q <= out_d; // [R10]
	end
	assign p.pin_out = out_q;
	assign p.pin_oe_n = ~drive;
endmodule : pin_mux

// ===== rtl/dual_address_gpio_port.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module dual_address_gpio_port
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Mode and power state
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic dram_area3,
	input wire logic dram_col_phase,
	// Address bus from the bus controller
	input wire gpio_pkg::port_t addr_low,
	input wire gpio_pkg::port_t addr_high,
	input wire logic [gpio_pkg::DRAM_MUX_BITS-1:0] dram_row_col,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire gpio_pkg::port_t low_pin_in,
	output gpio_pkg::port_t low_pin_out,
	output gpio_pkg::port_t low_pin_oe_n,
	input wire gpio_pkg::port_t high_pin_in,
	output gpio_pkg::port_t high_pin_out,
	output gpio_pkg::port_t high_pin_oe_n,
	output gpio_pkg::port_t high_pullup_on
);
	import gpio_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	mode_class_e mode_class;
	logic romless;
	logic expanded;
	logic single;
	logic clear_regs;
	assign mode_class = (mode_pins >= MODE_FIRST && mode_pins <= MODE_LAST_EXPANDED) ? MODE_ROMLESS :
		(mode_pins == MODE_SINGLE_CHIP) ? MODE_SINGLE : MODE_EXPANDED;
	assign romless = (mode_class == MODE_ROMLESS);
	assign expanded = (mode_class == MODE_EXPANDED);
	assign single = (mode_class == MODE_SINGLE);
	assign clear_regs = hw_standby; // [R9] [R12]

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	port_t low_s1_q;
	port_t low_s2_q;
	port_t high_s1_q;
	port_t high_s2_q;
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			low_s1_q <= REG_RESET;
			low_s2_q <= REG_RESET;
			high_s1_q <= REG_RESET;
			high_s2_q <= REG_RESET;
		end
		else
		begin
			low_s1_q <= low_pin_in;
			low_s2_q <= low_s1_q;
			high_s1_q <= high_pin_in;
			high_s2_q <= high_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode
	logic [ADDR_W-1:0] reg_index;
	logic access;
	logic wr_en;
	logic hit_low_dir;
	logic hit_high_dir;
	logic hit_low_data;
	logic hit_high_data;
	logic hit_pullup;
	logic hit_any;
	logic aligned;
	assign reg_index = paddr[ADDR_W+ADDR_SHIFT-1:ADDR_SHIFT];
	assign aligned = (paddr[ADDR_SHIFT-1:0] == '0);
	assign access = psel & penable;
	assign hit_low_dir = aligned && reg_index == LOW_DIR_ADDR;
	assign hit_high_dir = aligned && reg_index == HIGH_DIR_ADDR; // [R13]
	assign hit_low_data = aligned && reg_index == LOW_DATA_ADDR;
	assign hit_high_data = aligned && reg_index == HIGH_DATA_ADDR; // [R13]
	assign hit_pullup = aligned && reg_index == HIGH_PULLUP_ADDR; // [R14]
	assign hit_any = hit_low_dir | hit_high_dir | hit_low_data | hit_high_data | hit_pullup;
	assign wr_en = access & pwrite & hit_any;
	assign pready = 1'b1;
	assign pslverr = access & ~hit_any;

	////////////////////////////////////////////////////////////////////////
	// Registers
	port_t low_dir_q;
	port_t high_dir_q;
	port_t low_data_q;
	port_t high_data_q;
	port_t pullup_q;
	port_t wdata;
	port_t low_dir_d;
	port_t high_dir_d;
	port_t low_data_d;
	port_t high_data_d;
	port_t pullup_d;
	logic wr_low_dir;
	logic wr_high_dir;
	logic wr_low_data;
	logic wr_high_data;
	logic wr_pullup;
	assign wdata = pwdata[PORT_W-1:0];
	// Direction writes are dropped while the port is a fixed address bus
	assign wr_low_dir = wr_en & hit_low_dir & ~romless; // [R1]
	assign wr_high_dir = wr_en & hit_high_dir & ~romless; // [R2]
	assign wr_low_data = wr_en & hit_low_data; // [R12]
	assign wr_high_data = wr_en & hit_high_data;
	assign wr_pullup = wr_en & hit_pullup; // [R14]
	// Hardware standby wins over a write in the same cycle
	assign low_dir_d = clear_regs ? REG_RESET : (wr_low_dir ? wdata : low_dir_q); // [R9]
	assign high_dir_d = clear_regs ? REG_RESET : (wr_high_dir ? wdata : high_dir_q); // [R9]
	assign low_data_d = clear_regs ? REG_RESET : (wr_low_data ? wdata : low_data_q); // [R12]
	assign high_data_d = clear_regs ? REG_RESET : (wr_high_data ? wdata : high_data_q);
	assign pullup_d = clear_regs ? REG_RESET : (wr_pullup ? wdata : pullup_q); // [R14]

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			low_dir_q <= REG_RESET; // [R9]
		else
			low_dir_q <= low_dir_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			high_dir_q <= REG_RESET; // [R5] [R9]
		else
			high_dir_q <= high_dir_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			low_data_q <= REG_RESET; // [R12]
		else
			low_data_q <= low_data_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			high_data_q <= REG_RESET;
		else
			high_data_q <= high_data_d;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			pullup_q <= REG_RESET; // [R14]
		else
			pullup_q <= pullup_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Effective directions and address sources
	port_t low_dir_eff;
	port_t high_dir_eff;
	port_t high_addr_src;
	assign low_dir_eff = romless ? ALL_ONES : low_dir_q; // [R1] [R16]
	assign high_dir_eff = romless ? ALL_ONES : high_dir_q; // [R2]
	// DRAM row/column replaces the two lowest high-port address bits
	assign high_addr_src = dram_area3 ?
		{addr_high[PORT_W-1:DRAM_MUX_BITS], dram_row_col} : addr_high; // [R15]

	////////////////////////////////////////////////////////////////////////
	// Pin muxes
	port_regs_if low_if ();
	port_regs_if high_if ();
	assign low_if.dir = low_dir_eff;
	assign low_if.latch = low_data_q;
	assign low_if.addr = addr_low;
	assign low_if.pin_in = low_s2_q;
	assign low_if.addr_mode = romless | expanded; // [R3] [R16]
	assign low_if.latch_mode = single; // [R6]
	assign low_if.hold = sw_standby; // [R10]
	assign high_if.dir = high_dir_eff;
	assign high_if.latch = high_data_q;
	assign high_if.addr = high_addr_src;
	assign high_if.pin_in = high_s2_q;
	assign high_if.addr_mode = romless | expanded; // [R4]
	assign high_if.latch_mode = single; // [R7]
	assign high_if.hold = sw_standby; // [R10]

	pin_mux u_low
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.p(low_if.pin)
	);
	pin_mux u_high
	(
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.p(high_if.pin)
	);
	assign low_pin_out = low_if.pin_out;
	assign low_pin_oe_n = low_if.pin_oe_n;
	assign high_pin_out = high_if.pin_out;
	assign high_pin_oe_n = high_if.pin_oe_n;
	assign high_pullup_on = (romless | hw_standby) ? REG_RESET : (pullup_q & ~high_dir_q); // [R18]

	////////////////////////////////////////////////////////////////////////
	// Read data
	port_t rd_byte;
	always_comb
	begin
		rd_byte = REG_RESET;
		if (hit_low_dir || hit_high_dir)
			rd_byte = ALL_ONES; // [R1] [R8]
		else if (hit_low_data)
			rd_byte = low_if.readback; // [R11]
		else if (hit_high_data)
			rd_byte = high_if.readback; // [R17]
		else if (hit_pullup)
			rd_byte = pullup_q;
	end
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
			prdata <= {24'h00_0000, rd_byte};
	end
endmodule : dual_address_gpio_port

// ===== tb/gpio_pins_model.sv
`timescale 1ns/1ps
module gpio_pins_model
(
	// Clock
	input wire logic clk_sys,
	// Block side
	input wire gpio_pkg::port_t out,
	input wire gpio_pkg::port_t oe_n,
	input wire gpio_pkg::port_t pu,
	// Load side
	input wire gpio_pkg::port_t ext,
	input wire logic ext_en,
	output gpio_pkg::port_t pin
);
	import gpio_pkg::*;
	port_t last_q = 8'h00;
	// A floating pin without pull-up shows the inverse of its last level
	assign pin = (~oe_n & out) | (oe_n & (ext_en ? ext : (pu | ~last_q)));
	always_ff @(posedge clk_sys)
		last_q <= pin;
endmodule : gpio_pins_model

// ===== tb/dual_address_gpio_port_properties.sv
`timescale 1ns/1ps
module dual_address_gpio_port_properties
(
	// Clock, reset and mode
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [2:0] mode_pins,
	input wire logic hw_standby,
	input wire logic sw_standby,
	input wire logic dram_area3,
	// Sources and bus
	input wire gpio_pkg::port_t addr_low,
	input wire gpio_pkg::port_t addr_high,
	input wire logic [gpio_pkg::DRAM_MUX_BITS-1:0] dram_row_col,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [17:0] paddr,
	input wire logic [31:0] prdata,
	// Pins
	input wire gpio_pkg::port_t low_pin_out,
	input wire gpio_pkg::port_t low_pin_oe_n,
	input wire gpio_pkg::port_t high_pin_out,
	input wire gpio_pkg::port_t high_pin_oe_n,
	input wire gpio_pkg::port_t high_pullup_on
);
	import gpio_pkg::*;
	wire rom = mode_pins >= MODE_FIRST && mode_pins <= MODE_LAST_EXPANDED;
	wire run = rom && !sw_standby && !hw_standby;
	wire dir_hit = paddr == {LOW_DIR_ADDR, 2'b00} || paddr == {HIGH_DIR_ADDR, 2'b00};
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_romless_drive: assert property (rom && !hw_standby |-> low_pin_oe_n == 8'h00 && high_pin_oe_n == 8'h00)
		else $error("address mode pin not driving");
	a_low_addr_out: assert property (run |=> low_pin_out == $past(addr_low))
		else $error("low port not on address bus");
	a_high_addr_out: assert property (run |=> high_pin_out == ($past(dram_area3) ?
		{$past(addr_high[7:2]), $past(dram_row_col)} : $past(addr_high))) else $error("high port address wrong");
	a_pullup_off: assert property (rom || hw_standby |-> high_pullup_on == 8'h00)
		else $error("pull-up on in address mode or standby");
	a_pullup_rule: assert property (!rom && !hw_standby |-> (high_pullup_on & ~high_pin_oe_n) == 8'h00)
		else $error("pull-up on while driving");
	a_dir_reads_ones: assert property (psel && penable && !pwrite && dir_hit |-> prdata == 32'h0000_00ff)
		else $error("direction read not all ones");
	a_sw_hold: assert property ((sw_standby && !hw_standby) [*3] |-> $stable(low_pin_out) && $stable(high_pin_out))
		else $error("pin level moved in software standby");
	a_hw_clear: assert property (!rom && hw_standby [*2] |-> low_pin_oe_n == 8'hff && high_pin_oe_n == 8'hff)
		else $error("direction not cleared in hardware standby");
endmodule : dual_address_gpio_port_properties
bind dual_address_gpio_port dual_address_gpio_port_properties chk (.clk_sys, .rst_n, .mode_pins, .hw_standby,
	.sw_standby, .dram_area3, .addr_low, .addr_high, .dram_row_col, .psel, .penable, .pwrite, .paddr, .prdata,
	.low_pin_out, .low_pin_oe_n, .high_pin_out, .high_pin_oe_n, .high_pullup_on);

// ===== tb/dual_address_gpio_port_tb_top.sv
`timescale 1ns/1ps
module dual_address_gpio_port_tb_top;
	import gpio_pkg::*;
	logic clk_sys = 1'b0, rst_n = 1'b0, hw_standby = 1'b0, sw_standby = 1'b0, dram_area3 = 1'b0, ext_en = 1'b1;
	logic [2:0] mode_pins = 3'h7;
	port_t addr_low = 8'h00, addr_high = 8'h00, ext_low = 8'h00, ext_high = 8'h00;
	logic [DRAM_MUX_BITS-1:0] dram_row_col = 2'h0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
	logic [17:0] paddr = 18'h0_0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdata;
	port_t low_pin_in, low_pin_out, low_pin_oe_n, high_pin_in, high_pin_out, high_pin_oe_n, high_pullup_on;
	int n_fail = 0, comparisons = 0, cycles = 0;
	always #2.5 clk_sys = ~clk_sys;
	dual_address_gpio_port dut (.clk_sys, .rst_n, .mode_pins, .hw_standby, .sw_standby, .dram_area3,
		.dram_col_phase(1'b0), .addr_low, .addr_high, .dram_row_col, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .low_pin_in, .low_pin_out, .low_pin_oe_n, .high_pin_in, .high_pin_out,
		.high_pin_oe_n, .high_pullup_on);
	gpio_pins_model low_m (.clk_sys, .out(low_pin_out), .oe_n(low_pin_oe_n), .pu(8'h00), .ext(ext_low),
		.ext_en(1'b1), .pin(low_pin_in));
	gpio_pins_model high_m (.clk_sys, .out(high_pin_out), .oe_n(high_pin_oe_n), .pu(high_pullup_on),
		.ext(ext_high), .ext_en, .pin(high_pin_in));
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [15:0] off, input logic [31:0] wd);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {off, 2'b00};
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [15:0] off, input logic [31:0] exp);
		apb(1'b0, off, 32'h0000_0000);
		check(rdata, exp);
	endtask : rd
	task automatic start(input logic [2:0] m);
		@(posedge clk_sys);
		rst_n <= 1'b0;
		mode_pins <= m;
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
	endtask : start
	////////////////////////////////////////////////////////////////
	task automatic s_romless;
		start(3'h2);
		addr_low <= 8'h5a;
		addr_high <= 8'hc3;
		dram_area3 <= 1'b1;
		dram_row_col <= 2'h2;
		apb(1'b1, LOW_DIR_ADDR, 32'h0000_0000);
		apb(1'b1, HIGH_PULLUP_ADDR, 32'h0000_00ff);
		@(posedge clk_sys);
		check(low_pin_oe_n, 8'h00);
		check(high_pin_oe_n, 8'h00);
		check(low_pin_out, 8'h5a);
		check(high_pin_out, 8'hc2);
		check(high_pullup_on, 8'h00);
		rd(LOW_DIR_ADDR, 32'h0000_00ff);
		rd(HIGH_PULLUP_ADDR, 32'h0000_00ff);
	endtask : s_romless
	task automatic s_expanded;
		start(3'h5);
		check(high_pin_oe_n, 8'hff);
		rd(HIGH_PULLUP_ADDR, 32'h0000_0000);
		addr_low <= 8'h69;
		addr_high <= 8'h96;
		dram_area3 <= 1'b0;
		ext_en <= 1'b0;
		apb(1'b1, LOW_DIR_ADDR, 32'h0000_000f);
		apb(1'b1, HIGH_DIR_ADDR, 32'h0000_000f);
		apb(1'b1, HIGH_PULLUP_ADDR, 32'h0000_00ff);
		repeat (4) @(posedge clk_sys);
		check(low_pin_oe_n, 8'hf0);
		check(high_pin_oe_n, 8'hf0);
		check(low_pin_out[3:0], 4'h9);
		check(high_pin_out[3:0], 4'h6);
		check(high_pullup_on, 8'hf0);
		rd(HIGH_DATA_ADDR, 32'h0000_00f0);
		rd(HIGH_DIR_ADDR, 32'h0000_00ff);
		ext_en <= 1'b1;
	endtask : s_expanded
	task automatic s_single;
		start(3'h7);
		ext_low <= 8'h3c;
		ext_high <= 8'h3c;
		apb(1'b1, LOW_DIR_ADDR, 32'h0000_00f0);
		apb(1'b1, LOW_DATA_ADDR, 32'h0000_00a5);
		apb(1'b1, HIGH_DIR_ADDR, 32'h0000_000f);
		apb(1'b1, HIGH_DATA_ADDR, 32'h0000_005a);
		repeat (4) @(posedge clk_sys);
		check(low_pin_out[7:4], 4'ha);
		check(low_pin_oe_n, 8'h0f);
		check(high_pin_out[3:0], 4'ha);
		check(high_pin_oe_n, 8'hf0);
		rd(LOW_DATA_ADDR, 32'h0000_00ac);
		rd(HIGH_DATA_ADDR, 32'h0000_003a);
		sw_standby <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check(low_pin_out[7:4], 4'ha);
		check(low_pin_oe_n, 8'h0f);
		sw_standby <= 1'b0;
		rd(LOW_DATA_ADDR, 32'h0000_00ac);
		hw_standby <= 1'b1;
		repeat (3) @(posedge clk_sys);
		check(low_pin_oe_n, 8'hff);
		hw_standby <= 1'b0;
		apb(1'b1, LOW_DIR_ADDR, 32'h0000_00ff);
		rd(LOW_DATA_ADDR, 32'h0000_0000);
		apb(1'b0, 16'hffc4, 32'h0000_0000);
		check(err, 1'b1);
	endtask : s_single
	initial
	begin
		s_romless();
		s_expanded();
		s_single();
		report_and_stop();
	end
endmodule : dual_address_gpio_port_tb_top
